// file: hdl/tpl_pkg.sv
// Shared constants for the tuner synthesizer control front end
package tpl_pkg;
  // Bus select pin levels as seen by the level sensor
  localparam logic [1:0] SEL_GND = 2'h0;
  localparam logic [1:0] SEL_OPEN = 2'h1;
  localparam logic [1:0] SEL_VCC = 2'h3;
  // Three-wire word lengths
  localparam logic [4:0] LEN_SHORT = 5'h12;
  localparam logic [4:0] LEN_MID = 5'h13;
  localparam logic [4:0] LEN_LONG = 5'h1b;
  localparam logic [4:0] LEN_SAT = 5'h1f;
  localparam int WORD_W = 27;
  // Word length classes reported out
  localparam logic [1:0] CLS_NONE = 2'h0;
  localparam logic [1:0] CLS_SHORT = 2'h1;
  localparam logic [1:0] CLS_MID = 2'h2;
  localparam logic [1:0] CLS_LONG = 2'h3;
  // Reference divider values
  localparam logic [7:0] REF_64 = 8'h40;
  localparam logic [7:0] REF_80 = 8'h50;
  localparam logic [7:0] REF_128 = 8'h80;
  // Divider limits
  localparam logic [9:0] M_MAX_LONG = 10'h3ff;
  localparam logic [9:0] M_MAX_SHORT = 10'h1ff;
  localparam int LO_W = 15;
  // Two-wire addressing: fixed upper five bits of the address byte
  localparam logic [4:0] ADDR_FIXED = 5'h18;
  // Control byte field positions
  localparam int CB_CP = 6;
  localparam int CB_CD = 4;
  localparam int CB_R1 = 2;
  localparam int CB_R0 = 1;
  localparam int CB_OS = 0;
  // Status byte constant bits 5..3
  localparam logic [2:0] STAT_ONES = 3'h7;
  // Two-wire receive byte pairing
  localparam logic [1:0] PEND_NONE = 2'h0;
  localparam logic [1:0] PEND_DIV = 2'h1;
  localparam logic [1:0] PEND_CTRL = 2'h2;
  typedef enum logic [2:0] {
    TW_IDLE = 3'h0,
    TW_ADDR = 3'h1,
    TW_ACKA = 3'h3,
    TW_WRB = 3'h2,
    TW_ACKW = 3'h6,
    TW_RD = 3'h7,
    TW_RDACK = 3'h5
  } tpl_tw_state_t;
endpackage

// file: hdl/tpl_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module tpl_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // tpl_sync
`default_nettype wire

// file: hdl/tpl_front_end.sv
// Bus mode select, serial word decode and divider setup for the tuner synthesizer
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Mode pin level picks two- or three-wire bus
// - Count enable-window bits, classify 18/19/27
// - Reference divider from pin level and length
// - LO ratio is thirty-two M plus S
// - Binary M,S; S below M, M limited
// - Power-up clears frequency and band switches
// - Address read/write bit sets transfer direction
// - Lock pin: converter input and lock output
// - Sample on clock rise, apply on enable fall
// - Eighteen-bit word forces top main bit zero
// - Ratio code 01=128, 11=64, x0=80
module tpl_front_end (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0] bus_select_pin,
  input wire logic serial_clock_pin,
  input wire logic serial_data_pin,
  input wire logic addr_select_or_enable_pin,
  input wire logic [1:0] addr_select_level,
  input wire logic lock_detect,
  input wire logic [2:0] adc_level,
  output logic serialDataOut,
  output logic serialDataOeN,
  output logic lockOut,
  output logic threeWireMode,
  output logic [1:0] wordClass,
  output logic [9:0] mainRatio,
  output logic [4:0] swallowCount,
  output logic [7:0] refDivider,
  output logic [tpl_pkg::LO_W-1:0] loDivideRatio,
  output logic [3:0] bandSwitch,
  output logic chargePumpHigh,
  output logic chargePumpOff,
  output logic varicapOff
);
  import tpl_pkg::*;

  function automatic logic [7:0] refFromCode(input logic hi, input logic lo);
    if (!lo) return REF_80;
    return hi ? REF_64 : REF_128;
  endfunction

  logic [1:0] selS;
  logic sclS, sdaS, enS;
  logic [1:0] addrS;
  logic lockS;
  logic [2:0] adcS;
  tpl_sync #(.W(11)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in({bus_select_pin, serial_clock_pin, serial_data_pin, addr_select_or_enable_pin,
               addr_select_level, lock_detect, adc_level}),
    .sync_out({selS, sclS, sdaS, enS, addrS, lockS, adcS})
  );

  logic sclPrev_ff, sdaPrev_ff, enPrev_ff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sclPrev_ff <= 1'b0;
      sdaPrev_ff <= 1'b1;
      enPrev_ff <= 1'b0;
    end else begin
      sclPrev_ff <= sclS;
      sdaPrev_ff <= sdaS;
      enPrev_ff <= enS;
    end
  end
  logic sclRise, sclFall, enRise, enFall, twStart, twStop;
  assign sclRise = sclS && !sclPrev_ff;
  assign sclFall = !sclS && sclPrev_ff;
  assign enRise = enS && !enPrev_ff;
  assign enFall = !enS && enPrev_ff;
  assign twStart = sclS && sclPrev_ff && sdaPrev_ff && !sdaS;
  assign twStop = sclS && sclPrev_ff && !sdaPrev_ff && sdaS;

  // Mode pin is sampled only between transfers so a glitch cannot split a word
  tpl_tw_state_t twState_ff;
  logic pinHigh_ff;
  logic busIdle;
  assign busIdle = threeWireMode ? !enS : (twState_ff == TW_IDLE);
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      threeWireMode <= 1'b0;
      pinHigh_ff <= 1'b0;
    end else if (busIdle) begin
      threeWireMode <= (selS != SEL_GND);
      pinHigh_ff <= (selS == SEL_VCC);
    end
  end

  // Three-wire receive
  logic [WORD_W-1:0] word_ff;
  logic [4:0] bitCnt_ff;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      word_ff <= '0;
      bitCnt_ff <= 5'h0;
    end else if (threeWireMode) begin
      if (enRise) begin
        bitCnt_ff <= 5'h0;
      end else if (enS && sclRise) begin
        word_ff <= {word_ff[WORD_W-2:0], sdaS};
        if (bitCnt_ff != LEN_SAT) begin
          bitCnt_ff <= bitCnt_ff + 5'h1;
        end
      end
    end
  end

  // Apply strobes from both bus paths; only the selected one ever fires
  logic twLoad, twFreq, twCtrl;
  logic [9:0] twM;
  logic [4:0] twS;
  logic [7:0] twCtrlByte;
  logic [3:0] twBand;
  logic [9:0] wM;
  logic [4:0] wS;
  logic [3:0] wBand;
  logic [7:0] wTest;
  logic wValid;
  always_comb begin
    wValid = threeWireMode && enFall;
    wM = 10'h0;
    wS = 5'h0;
    wBand = 4'h0;
    wTest = 8'h0;
    unique case (bitCnt_ff)
      LEN_SHORT: begin
        wBand = word_ff[17:14];
        wM = {1'b0, word_ff[13:5]};
        wS = word_ff[4:0];
      end
      LEN_MID: begin
        wBand = word_ff[18:15];
        wM = word_ff[14:5];
        wS = word_ff[4:0];
      end
      LEN_LONG: begin
        wBand = word_ff[26:23];
        wM = word_ff[22:13];
        wS = word_ff[12:8];
        wTest = word_ff[7:0];
      end
      default: wValid = 1'b0;
    endcase
  end

  logic [9:0] newM;
  logic [4:0] newS;
  logic freqOk;
  assign newM = threeWireMode ? wM : twM;
  assign newS = threeWireMode ? wS : twS;
  assign freqOk = ({5'h0, newS} < newM) && (newM <= M_MAX_LONG);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mainRatio <= 10'h0;
      swallowCount <= 5'h0;
      bandSwitch <= 4'h0;
      refDivider <= REF_80;
      chargePumpHigh <= 1'b0;
      chargePumpOff <= 1'b0;
      varicapOff <= 1'b0;
      wordClass <= CLS_NONE;
    end else if (wValid) begin
      bandSwitch <= wBand;
      if (freqOk) begin
        mainRatio <= wM;
        swallowCount <= wS;
      end
      if (bitCnt_ff == LEN_LONG) begin
        wordClass <= CLS_LONG;
        refDivider <= refFromCode(wTest[CB_R1], wTest[CB_R0]);
        chargePumpHigh <= wTest[CB_CP];
        chargePumpOff <= wTest[CB_CD];
        varicapOff <= wTest[CB_OS];
      end else if (bitCnt_ff == LEN_SHORT) begin
        wordClass <= CLS_SHORT;
        refDivider <= pinHigh_ff ? REF_80 : REF_64;
      end else begin
        wordClass <= CLS_MID;
        refDivider <= pinHigh_ff ? REF_80 : REF_128;
      end
    end else if (twLoad) begin
      if (twFreq && freqOk) begin
        mainRatio <= twM;
        swallowCount <= twS;
      end
      if (twCtrl) begin
        bandSwitch <= twBand;
        refDivider <= refFromCode(twCtrlByte[CB_R1], twCtrlByte[CB_R0]);
        chargePumpHigh <= twCtrlByte[CB_CP];
        chargePumpOff <= twCtrlByte[CB_CD];
        varicapOff <= twCtrlByte[CB_OS];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      loDivideRatio <= '0;
    end else begin
      loDivideRatio <= {mainRatio, 5'h0} + {10'h0, swallowCount};
    end
  end

  // Two-wire slave
  logic [7:0] rxSh_ff, txSh_ff, pendByte_ff;
  logic [3:0] twCnt_ff;
  logic readDir_ff, masterAck_ff;
  logic [1:0] pend_ff;
  logic [7:0] statusByte;
  assign statusByte = {1'b0, lockS, STAT_ONES, adcS};
  assign twM = {pendByte_ff[6:0], rxSh_ff[7:5]};
  assign twS = rxSh_ff[4:0];
  assign twCtrlByte = pendByte_ff;
  assign twBand = rxSh_ff[3:0];
  logic byteDone;
  assign byteDone = sclFall && (twCnt_ff == 4'h8);
  assign twLoad = !threeWireMode && (twState_ff == TW_WRB) && byteDone && (pend_ff != PEND_NONE);
  assign twFreq = (pend_ff == PEND_DIV);
  assign twCtrl = (pend_ff == PEND_CTRL);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      twState_ff <= TW_IDLE;
      rxSh_ff <= 8'h0;
      txSh_ff <= 8'h0;
      pendByte_ff <= 8'h0;
      twCnt_ff <= 4'h0;
      readDir_ff <= 1'b0;
      masterAck_ff <= 1'b0;
      pend_ff <= PEND_NONE;
      serialDataOeN <= 1'b1;
    end else if (threeWireMode) begin
      twState_ff <= TW_IDLE;
      serialDataOeN <= 1'b1;
    end else if (twStart) begin
      twState_ff <= TW_ADDR; // New start restarts even without a stop
      twCnt_ff <= 4'h0;
      pend_ff <= PEND_NONE;
      serialDataOeN <= 1'b1;
    end else if (twStop) begin
      twState_ff <= TW_IDLE;
      serialDataOeN <= 1'b1;
    end else begin
      unique case (twState_ff)
        TW_IDLE: begin
          serialDataOeN <= 1'b1;
        end
        TW_ADDR, TW_WRB: begin
          if (sclRise) begin
            rxSh_ff <= {rxSh_ff[6:0], sdaS};
            twCnt_ff <= twCnt_ff + 4'h1;
          end else if (byteDone) begin
            twCnt_ff <= 4'h0;
            if (twState_ff == TW_ADDR) begin
              if (rxSh_ff[7:1] == {ADDR_FIXED, addrS}) begin
                readDir_ff <= rxSh_ff[0];
                serialDataOeN <= 1'b0;
                twState_ff <= TW_ACKA;
              end else begin
                twState_ff <= TW_IDLE;
              end
            end else begin
              serialDataOeN <= 1'b0;
              twState_ff <= TW_ACKW;
              if (pend_ff == PEND_NONE) begin
                pendByte_ff <= rxSh_ff;
                pend_ff <= rxSh_ff[7] ? PEND_CTRL : PEND_DIV;
              end else begin
                pend_ff <= PEND_NONE;
              end
            end
          end
        end
        TW_ACKA: begin
          if (sclFall) begin
            if (readDir_ff) begin
              serialDataOeN <= statusByte[7];
              txSh_ff <= {statusByte[6:0], 1'b0};
              twCnt_ff <= 4'h1;
              twState_ff <= TW_RD;
            end else begin
              serialDataOeN <= 1'b1;
              twState_ff <= TW_WRB;
            end
          end
        end
        TW_ACKW: begin
          if (sclFall) begin
            serialDataOeN <= 1'b1;
            twState_ff <= TW_WRB;
          end
        end
        TW_RD: begin
          if (sclFall) begin
            if (twCnt_ff == 4'h8) begin
              serialDataOeN <= 1'b1;
              twState_ff <= TW_RDACK;
            end else begin
              serialDataOeN <= txSh_ff[7];
              txSh_ff <= {txSh_ff[6:0], 1'b0};
              twCnt_ff <= twCnt_ff + 4'h1;
            end
          end
        end
        TW_RDACK: begin
          if (sclRise) begin
            masterAck_ff <= !sdaS;
          end else if (sclFall) begin
            if (masterAck_ff) begin
              serialDataOeN <= statusByte[7];
              txSh_ff <= {statusByte[6:0], 1'b0};
              twCnt_ff <= 4'h1;
              twState_ff <= TW_RD;
            end else begin
              twState_ff <= TW_IDLE;
            end
          end
        end
        default: begin
          twState_ff <= TW_IDLE;
          serialDataOeN <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      serialDataOut <= 1'b0;
      lockOut <= 1'b0;
    end else begin
      serialDataOut <= 1'b0; // Open drain: only ever pulls low
      lockOut <= lockS;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  mode_from_pin_a: assert property (busIdle && (selS == SEL_GND) |=> !threeWireMode)
    else $error("two-wire mode not taken from grounded pin");
  mode_held_a: assert property (!busIdle |=> $stable(threeWireMode))
    else $error("bus mode changed during a transfer");
  short_top_a: assert property (wValid && bitCnt_ff == LEN_SHORT |=> !mainRatio[9] && wordClass == CLS_SHORT)
    else $error("short word left top main bit set");
  ref_short_a: assert property (wValid && bitCnt_ff == LEN_SHORT && !pinHigh_ff |=> refDivider == REF_64)
    else $error("short word with open pin not divider 64");
  ref_mid_a: assert property (wValid && bitCnt_ff == LEN_MID && pinHigh_ff |=> refDivider == REF_80)
    else $error("mid word with high pin not divider 80");
  ref_code_a: assert property (twLoad && twCtrl && !twCtrlByte[CB_R0] |=> refDivider == REF_80)
    else $error("ratio code low bit zero not divider 80");
  lo_ratio_a: assert property ($stable(mainRatio) && $stable(swallowCount)
      |=> loDivideRatio == LO_W'(32 * $past(mainRatio) + $past(swallowCount)))
    else $error("LO ratio not 32M plus S");
  swallow_below_a: assert property (mainRatio != 10'h0 |-> {5'h0, swallowCount} < mainRatio)
    else $error("swallow count not below main ratio");
  sample_rise_a: assert property (threeWireMode && enS && sclRise && bitCnt_ff < LEN_LONG
      |=> bitCnt_ff == $past(bitCnt_ff) + 5'h1 && word_ff[0] == $past(sdaS))
    else $error("data bit not taken on clock rise");
  read_dir_a: assert property (twState_ff == TW_ACKA && sclFall && readDir_ff |=> twState_ff == TW_RD)
    else $error("read address did not start status send");
endmodule // tpl_front_end
`default_nettype wire

// file: dv/tpl_host_model.sv
// Host-side serial master model for the three-wire link
`timescale 1ns/1ps
`default_nettype none
module tpl_host_model (
  input wire logic clk_sys,
  output logic serialClock,
  output logic serialData,
  output logic serialEnable
);
  initial begin
    serialClock = 1'b0;
    serialData = 1'b0;
    serialEnable = 1'b0;
  end
  // Half link period: 8 system clocks give an 80 ns link clock
  task automatic half();
    repeat (8) @(negedge clk_sys);
  endtask
  // Clock stands low outside frames
  task automatic send(input logic [26:0] word, input int len);
    int i;
    serialEnable = 1'b1;
    half();
    for (i = len - 1; i >= 0; i--) begin
      serialData = word[i];
      half();
      serialClock = 1'b1;
      half();
      serialClock = 1'b0;
    end
    half();
    serialEnable = 1'b0;
    half();
    // Hold time over, so no stale bit is left on the wire
    serialData = ~serialData;
  endtask
endmodule // tpl_host_model
`default_nettype wire

// file: dv/tuner_pll_bus_mode_and_divider_setup_tb.sv
// Self-checking bench for the tuner synthesizer control front end
`timescale 1ns/1ps
`default_nettype none
`define TPL_CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tuner_pll_bus_mode_and_divider_setup_tb;
  import tpl_pkg::*;
  typedef struct packed {
    logic [1:0] cls;
    logic [9:0] m;
    logic [4:0] s;
    logic [7:0] rd;
    logic [3:0] bs;
    logic [2:0] ctl;
  } tpl_note_t;
  logic clk_sys, sys_rst, sClk, sData, sEn, lockIn;
  logic [1:0] busPin;
  logic sdOut, sdOeN, lockOut, threeWireMode, cpHigh, cpOff, vcOff;
  logic [1:0] wordClass;
  logic [9:0] mainRatio, m;
  logic [4:0] swallowCount, s;
  logic [7:0] refDivider, tb;
  logic [LO_W-1:0] loDivideRatio;
  logic [3:0] bandSwitch;
  tpl_note_t expState, exp;
  tpl_note_t notes[$];
  int fails, checks, seed, cycles, k;

  tpl_front_end dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_select_pin(busPin), .serial_clock_pin(sClk),
    .serial_data_pin(sData), .addr_select_or_enable_pin(sEn), .addr_select_level(2'h1), .lock_detect(lockIn),
    .adc_level(3'h0), .serialDataOut(sdOut), .serialDataOeN(sdOeN), .lockOut(lockOut),
    .threeWireMode(threeWireMode), .wordClass(wordClass), .mainRatio(mainRatio), .swallowCount(swallowCount),
    .refDivider(refDivider), .loDivideRatio(loDivideRatio), .bandSwitch(bandSwitch), .chargePumpHigh(cpHigh),
    .chargePumpOff(cpOff), .varicapOff(vcOff));
  tpl_host_model host (.clk_sys(clk_sys), .serialClock(sClk), .serialData(sData), .serialEnable(sEn));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Seventeen words of 296 to 456 cycles each
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  // Notes the expected outcome, then sends the word
  task automatic xfer(input int len, input logic [3:0] bs, input logic [9:0] mr, input logic [4:0] sc,
    input logic [7:0] tbyte);
    logic [26:0] w;
    w = (len == 27) ? {bs, mr, sc, tbyte} : (len == 19) ? {8'h00, bs, mr, sc} : {9'h000, bs, mr[8:0], sc};
    if (threeWireMode === 1'b1 && (len == 18 || len == 19 || len == 27)) begin
      expState.cls = (len == 18) ? CLS_SHORT : (len == 19) ? CLS_MID : CLS_LONG;
      expState.bs = bs;
      if (len == 27) begin
        expState.rd = !tbyte[CB_R0] ? REF_80 : tbyte[CB_R1] ? REF_64 : REF_128;
        expState.ctl = {tbyte[CB_CP], tbyte[CB_CD], tbyte[CB_OS]};
      end else
        expState.rd = (busPin == SEL_VCC) ? REF_80 : (len == 18) ? REF_64 : REF_128;
      if (len == 18)
        mr[9] = 1'b0;
      if (sc < mr) begin
        expState.m = mr;
        expState.s = sc;
      end
    end
    notes.push_back(expState);
    host.send(w, len);
  endtask

  // Random M and S kept in range by the host
  task automatic pick();
    m = 10'($random(seed));
    if (m == 10'h000)
      m = 10'h001;
    s = 5'($random(seed));
    if (s >= m)
      s = 5'(m - 10'h001);
    tb = 8'($random(seed));
  endtask

  task automatic setSel(input logic [1:0] v, input logic mode);
    busPin = v;
    repeat (12) @(negedge clk_sys);
    `TPL_CHK("threeWireMode", mode, threeWireMode)
  endtask

  // Result watcher: applied 3 to 4 clocks after enable falls
  // Start late so the enable's first settling at time zero is not taken as a frame end
  initial begin
    #1;
    forever begin
    @(negedge sEn);
    repeat (6) @(posedge clk_sys);
    #1;
    exp = notes.pop_front();
    `TPL_CHK("wordClass", exp.cls, wordClass)
    `TPL_CHK("mainRatio", exp.m, mainRatio)
    `TPL_CHK("swallowCount", exp.s, swallowCount)
    `TPL_CHK("refDivider", exp.rd, refDivider)
    `TPL_CHK("bandSwitch", exp.bs, bandSwitch)
    `TPL_CHK("controlBits", exp.ctl, {cpHigh, cpOff, vcOff})
    `TPL_CHK("loDivideRatio", 15'({exp.m, 5'h00}) + 15'(exp.s), loDivideRatio)
    end
  end

  initial begin
    sys_rst = 1'b1;
    busPin = SEL_VCC;
    lockIn = 1'b0;
    seed = 32'h01b5;
    fails = 0;
    checks = 0;
    cycles = 0;
    expState = '{cls: CLS_NONE, m: 10'h000, s: 5'h00, rd: REF_80, bs: 4'h0, ctl: 3'h0};
    repeat (16) @(negedge clk_sys);
    `TPL_CHK("mainRatio", 10'h000, mainRatio)
    `TPL_CHK("bandSwitch", 4'h0, bandSwitch)
    `TPL_CHK("refDivider", REF_80, refDivider)
    sys_rst = 1'b0;
    setSel(SEL_VCC, 1'b1);
    $display("reset test done");
    for (k = 0; k < 8; k++) begin
      if (k == 4)
        setSel(SEL_OPEN, 1'b1);
      pick();
      xfer((k % 2) ? 19 : 18, 4'($random(seed)), m, s, tb);
    end
    $display("short word test done");
    for (k = 0; k < 4; k++) begin
      pick();
      tb[2:1] = 2'(k);
      xfer(27, 4'($random(seed)), m, s, tb);
    end
    $display("long word test done");
    // Lengths off the list and S not below M
    xfer(17, 4'hf, 10'h155, 5'h03, 8'h00);
    xfer(20, 4'h3, 10'h0aa, 5'h04, 8'h00);
    xfer(19, 4'ha, 10'h005, 5'h05, 8'h00);
    $display("refusal test done");
    // Pin moves mid-word: mode holds until the bus is idle
    pick();
    fork
      xfer(27, 4'h5, m, s, tb);
      begin
        repeat (100) @(negedge clk_sys);
        busPin = SEL_GND;
      end
    join
    repeat (12) @(negedge clk_sys);
    `TPL_CHK("threeWireMode", 1'b0, threeWireMode)
    xfer(19, 4'h9, 10'h077, 5'h01, 8'h00);
    `TPL_CHK("serialDataOeN", 1'b1, sdOeN)
    `TPL_CHK("serialDataOut", 1'b0, sdOut)
    $display("mode test done");
    lockIn = 1'b1;
    repeat (5) @(negedge clk_sys);
    `TPL_CHK("lockOut", 1'b1, lockOut)
    lockIn = 1'b0;
    repeat (5) @(negedge clk_sys);
    `TPL_CHK("lockOut", 1'b0, lockOut)
    $display("lock test done");
    repeat (20) @(negedge clk_sys);
    stop_test();
  end
endmodule // tuner_pll_bus_mode_and_divider_setup_tb
`default_nettype wire
